/* File: verilog/stiu_skip_unit.v */
/*
 * Skip test instruction unit: evaluates the four conditional-skip
 * instructions, holds the two request flags they test and clear, and
 * exposes the interrupt control bits over an AHB-Lite slave.
 * Assumes one core clock; instr_valid marks each instruction cycle
 * and all inputs are synchronous to mclk.
 */
// Design decisions made here: the register offsets and register access over AHB-Lite.
`include "stiu_defs.vh"
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Skip next when accumulator equals memory word
// - Enable clear: flag set clears, skips next
// - Ext enable bit0 set: instruction is no-op
// - Conv enable clear: flag set clears, skips
// - Conv enable bit2 set: instruction is no-op
// - Skip when pin level matches polarity bit
module stiu_skip_unit #(
    parameter DATA_W = 4,
    parameter INSTR_W = 10
) (
    // Clock and reset.
    input  wire                 mclk,
    input  wire                 rst,
    // Instruction stream from the core.
    input  wire                 instr_valid,
    input  wire [INSTR_W-1:0]   instr_word,
    input  wire [DATA_W-1:0]    acc_value,
    input  wire [DATA_W-1:0]    mem_at_data_pointer,
    // Event and pin inputs.
    input  wire                 ext_request_set,
    input  wire                 conv_done_set,
    input  wire                 ext_irq_pin,
    // Skip results to the core.
    output reg                  skip_taken_r,
    output reg                  instr_suppressed_r,
    output reg                  skip_pending_r,
    output reg                  ext_request_flag_r,
    output reg                  conv_done_flag_r,
    // AHB-Lite slave.
    input  wire                 hsel,
    input  wire [31:0]          haddr,
    input  wire [1:0]           htrans,
    input  wire                 hwrite,
    input  wire [2:0]           hsize,
    input  wire [31:0]          hwdata,
    input  wire                 hready,
    output reg  [31:0]          hrdata,
    output reg                  hreadyout,
    output reg                  hresp
);

    reg  [3:0]                  irq_control_first_r;
    reg  [3:0]                  irq_control_second_r;
    reg  [3:0]                  irq_input_control_r;
    reg                         wr_pend_r;
    reg  [`STIU_ADDR_MSB:0]     wr_addr_r;

    wire                        ext_irq_enable_bit;
    wire                        conv_irq_enable_bit;
    wire                        pin_polarity_bit;
    wire                        evaluate;
    wire                        is_acc_eq;
    wire                        is_ext_req;
    wire                        is_conv;
    wire                        is_pin;
    wire                        ext_clear;
    wire                        conv_clear;
    wire                        skip_cond;
    wire                        addr_phase;
    wire [`STIU_ADDR_MSB:0]     addr_lo;

    assign ext_irq_enable_bit  = irq_control_first_r[`STIU_EXT_EN_BIT];
    assign conv_irq_enable_bit = irq_control_second_r[`STIU_CONV_EN_BIT];
    assign pin_polarity_bit    = irq_input_control_r[`STIU_POL_BIT];

    // A skipped instruction is consumed here without being decoded.
    assign evaluate   = instr_valid & ~skip_pending_r;
    assign is_acc_eq  = evaluate & (instr_word == `STIU_OP_ACC_EQ_MEM);
    assign is_ext_req = evaluate & (instr_word == `STIU_OP_EXT_REQ);
    assign is_conv    = evaluate & (instr_word == `STIU_OP_CONV_DONE);
    assign is_pin     = evaluate & (instr_word == `STIU_OP_PIN_LEVEL);

    // With the enable bit set the test instruction leaves the flag alone.
    assign ext_clear  = is_ext_req & ~ext_irq_enable_bit & ext_request_flag_r;
    assign conv_clear = is_conv & ~conv_irq_enable_bit & conv_done_flag_r;

    assign skip_cond  = (is_acc_eq & (acc_value == mem_at_data_pointer))
                      | ext_clear
                      | conv_clear
                      | (is_pin & (ext_irq_pin == pin_polarity_bit));

    // Skip sequencing.
    always @(posedge mclk) begin
        if (rst) begin
            skip_taken_r       <= 1'b0;
            instr_suppressed_r <= 1'b0;
            skip_pending_r     <= 1'b0;
        end else begin
            skip_taken_r       <= skip_cond;
            instr_suppressed_r <= instr_valid & skip_pending_r;
            if (instr_valid) begin
                skip_pending_r <= skip_cond;
            end
        end
    end

    // Request flags; a set in the clearing cycle wins so no event is lost.
    always @(posedge mclk) begin
        if (rst) begin
            ext_request_flag_r <= 1'b0;
            conv_done_flag_r   <= 1'b0;
        end else begin
            if (ext_request_set) begin
                ext_request_flag_r <= 1'b1;
            end else if (ext_clear) begin
                ext_request_flag_r <= 1'b0;
            end
            if (conv_done_set) begin
                conv_done_flag_r <= 1'b1;
            end else if (conv_clear) begin
                conv_done_flag_r <= 1'b0;
            end
        end
    end

    // Register read view at a byte offset.
    function [31:0] read_reg;
        input [`STIU_ADDR_MSB:0] ofs;
        begin
            read_reg = `STIU_ZERO32;
            if (ofs == `STIU_OFS_CTRL_FIRST) begin
                read_reg[3:0] = irq_control_first_r;
            end else if (ofs == `STIU_OFS_CTRL_SECOND) begin
                read_reg[3:0] = irq_control_second_r;
            end else if (ofs == `STIU_OFS_INPUT_CTRL) begin
                read_reg[3:0] = irq_input_control_r;
            end else if (ofs == `STIU_OFS_STATUS) begin
                read_reg[`STIU_ST_EXT_BIT]  = ext_request_flag_r;
                read_reg[`STIU_ST_CONV_BIT] = conv_done_flag_r;
                read_reg[`STIU_ST_SKIP_BIT] = skip_pending_r;
            end
        end
    endfunction

    assign addr_phase = hsel & htrans[1] & hready;
    assign addr_lo    = haddr[`STIU_ADDR_MSB:0];

    // Bus slave: zero wait states, read data captured in the address
    // phase so the data phase can present it straight from a flop.
    always @(posedge mclk) begin
        if (rst) begin
            hrdata     <= `STIU_ZERO32;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= {(`STIU_ADDR_MSB+1){1'b0}};
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_r <= addr_phase & hwrite;
            if (addr_phase) begin
                wr_addr_r <= addr_lo;
            end
            if (addr_phase & ~hwrite) begin
                hrdata <= read_reg(addr_lo);
            end
        end
    end

    // Control registers take write data in the data phase.
    always @(posedge mclk) begin
        if (rst) begin
            irq_control_first_r  <= `STIU_CTRL_RESET;
            irq_control_second_r <= `STIU_CTRL_RESET;
            irq_input_control_r  <= `STIU_CTRL_RESET;
        end else if (wr_pend_r) begin
            if (wr_addr_r == `STIU_OFS_CTRL_FIRST) begin
                irq_control_first_r <= hwdata[3:0];
            end else if (wr_addr_r == `STIU_OFS_CTRL_SECOND) begin
                irq_control_second_r <= hwdata[3:0];
            end else if (wr_addr_r == `STIU_OFS_INPUT_CTRL) begin
                irq_input_control_r <= hwdata[3:0];
            end
        end
    end

endmodule
`default_nettype wire

/* File: verilog/stiu_defs.vh */
/*
 * Constants of the skip test instruction unit: opcodes, register
 * offsets, field positions and reset values.
 * Assumes inclusion by bare name from the unit's design file.
 */
`ifndef STIU_DEFS_VH
`define STIU_DEFS_VH

// Opcodes of the four conditional-skip instructions.
`define STIU_OP_ACC_EQ_MEM  10'h026
`define STIU_OP_EXT_REQ     10'h038
`define STIU_OP_CONV_DONE   10'h287
`define STIU_OP_PIN_LEVEL   10'h03a

// Register byte offsets.
`define STIU_OFS_CTRL_FIRST  8'h00
`define STIU_OFS_CTRL_SECOND 8'h04
`define STIU_OFS_INPUT_CTRL  8'h08
`define STIU_OFS_STATUS      8'h0c

// Field positions.
`define STIU_EXT_EN_BIT      0
`define STIU_CONV_EN_BIT     2
`define STIU_POL_BIT         2
`define STIU_ST_EXT_BIT      0
`define STIU_ST_CONV_BIT     1
`define STIU_ST_SKIP_BIT     2

// Reset values and address width.
`define STIU_CTRL_RESET      4'h0
`define STIU_ZERO32          32'h0000_0000
`define STIU_ADDR_MSB        7

`endif

/* File: verification/stiu_monitor.sv */
/* Assertions on the skip unit's instruction ports.
   Assumes it is bound onto stiu_skip_unit with a synchronous, active high reset. */
`timescale 1ns/1ns
`default_nettype none
module stiu_monitor (
    // Clock, reset and instruction stream.
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [3:0] acc_value,
    input wire logic [3:0] mem_at_data_pointer,
    input wire logic       ext_request_set,
    // Results.
    input wire logic       skip_taken_r,
    input wire logic       instr_suppressed_r,
    input wire logic       skip_pending_r,
    input wire logic       ext_request_flag_r,
    input wire logic       conv_done_flag_r
);
    // A pending skip swallows its slot, so only decoded slots count.
    wire go = instr_valid && !skip_pending_r;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_EQ_SKIP: assert property (go && instr_word == 10'h026 &&
        acc_value == mem_at_data_pointer |=> skip_taken_r && skip_pending_r) else $error("eq");
    AST_NE_RUN: assert property (go && instr_word == 10'h026 &&
        acc_value != mem_at_data_pointer |=> !skip_taken_r) else $error("ne");
    AST_EXT_IDLE: assert property (go && instr_word == 10'h038 &&
        !ext_request_flag_r |=> !skip_taken_r) else $error("ext idle");
    AST_EXT_CLR: assert property (go && instr_word == 10'h038 && !ext_request_set
        ##1 skip_taken_r |-> !ext_request_flag_r) else $error("ext clr");
    AST_EXT_KEEP: assert property (ext_request_flag_r &&
        !(go && instr_word == 10'h038) |=> ext_request_flag_r) else $error("ext keep");
    AST_CONV_IDLE: assert property (go && instr_word == 10'h287 &&
        !conv_done_flag_r |=> !skip_taken_r) else $error("conv idle");
    AST_CONV_KEEP: assert property (conv_done_flag_r &&
        !(go && instr_word == 10'h287) |=> $stable(conv_done_flag_r)) else $error("conv keep");
    AST_SLOT: assert property (skip_pending_r && instr_valid |=>
        instr_suppressed_r && !skip_pending_r && !skip_taken_r) else $error("slot");
    cover property (go && instr_word == 10'h038 ##1 skip_taken_r);
    cover property (go && instr_word == 10'h03a ##1 skip_taken_r);
    cover property (instr_suppressed_r);
endmodule
bind stiu_skip_unit stiu_monitor u_mon (.mclk, .rst, .instr_valid, .instr_word, .acc_value,
    .mem_at_data_pointer, .ext_request_set, .skip_taken_r, .instr_suppressed_r,
    .skip_pending_r, .ext_request_flag_r, .conv_done_flag_r);
`default_nettype wire

/* File: verification/test_skip_test_instruction_unit.sv */
/* Self-checking bench of the skip unit: a table of instruction cases, then hand tests.
   Assumes the unit's zero-wait AHB-Lite slave and its one-cycle instruction answer. */
`timescale 1ns/1ns
`default_nettype none
module test_skip_test_instruction_unit;
    logic        mclk, rst, instr_valid, ext_request_set, conv_done_set, ext_irq_pin;
    logic        hsel, hwrite;
    logic [9:0]  instr_word;
    logic [3:0]  acc_value, mem_at_data_pointer;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, rd;
    logic [26:0] rows [14];
    logic [26:0] r;
    wire  [31:0] hrdata;
    wire         hready, hresp, skip_taken_r, instr_suppressed_r, skip_pending_r;
    wire         ext_request_flag_r, conv_done_flag_r;
    int          err_count, cmp_count;
    stiu_skip_unit u_dut (.mclk, .rst, .instr_valid, .instr_word, .acc_value,
        .mem_at_data_pointer, .ext_request_set, .conv_done_set, .ext_irq_pin,
        .skip_taken_r, .instr_suppressed_r, .skip_pending_r, .ext_request_flag_r,
        .conv_done_flag_r, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout(hready), .hresp);
    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end
    task automatic conclude;
        $display("mismatches %0d of %0d checks", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // Bounded, so a slave that never answers ends the run instead of hanging it.
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge mclk);
        while (hready !== 1'h1) begin
            n++;
            if (n > 50) begin
                err_count++;
                conclude();
            end
            @(posedge mclk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, hsize} <= {1'h1, 2'h2, w, 3'h2};
        haddr <= {24'h0, a};
        wait_rdy();
        {hsel, htrans} <= 3'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic slot(input logic [9:0] w, input logic [3:0] a, input logic [3:0] m);
        {instr_valid, instr_word, acc_value, mem_at_data_pointer} <= {1'h1, w, a, m};
        @(posedge mclk);
    endtask
    initial begin
        {rst, instr_valid, ext_request_set, conv_done_set, ext_irq_pin, hsel, hwrite} = 7'h40;
        {instr_word, acc_value, mem_at_data_pointer, htrans, hsize, haddr, hwdata} = '0;
        err_count = 0;
        cmp_count = 0;
        rows = '{{6'h00, 10'h026, 4'h5, 4'h5, 3'h4}, {6'h00, 10'h026, 4'h5, 4'h4, 3'h0},
            {6'h02, 10'h038, 4'h0, 4'h0, 3'h4}, {6'h00, 10'h038, 4'h0, 4'h0, 3'h0},
            {6'h22, 10'h038, 4'h0, 4'h0, 3'h2}, {6'h00, 10'h038, 4'h0, 4'h0, 3'h4},
            {6'h01, 10'h287, 4'h0, 4'h0, 3'h4}, {6'h00, 10'h287, 4'h0, 4'h0, 3'h0},
            {6'h11, 10'h287, 4'h0, 4'h0, 3'h1}, {6'h00, 10'h287, 4'h0, 4'h0, 3'h4},
            {6'h00, 10'h03a, 4'h0, 4'h0, 3'h4}, {6'h04, 10'h03a, 4'h0, 4'h0, 3'h0},
            {6'h0c, 10'h03a, 4'h0, 4'h0, 3'h4}, {6'h08, 10'h03a, 4'h0, 4'h0, 3'h0}};
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        for (int i = 0; i < 14; i++) begin
            r = rows[i];
            bus(1'h1, 8'h00, {31'h0, r[26]});
            bus(1'h1, 8'h04, {29'h0, r[25], 2'h0});
            bus(1'h1, 8'h08, {29'h0, r[24], 2'h0});
            ext_irq_pin <= r[23];
            {ext_request_set, conv_done_set} <= r[22:21];
            @(posedge mclk);
            {ext_request_set, conv_done_set} <= 2'h0;
            slot(r[20:11], r[10:7], r[6:3]);
            slot(10'h000, 4'h0, 4'h0);
            chk("skip", {31'h0, r[2]}, {31'h0, skip_taken_r});
            chk("flags", {30'h0, r[1:0]}, {30'h0, ext_request_flag_r, conv_done_flag_r});
            instr_valid <= 1'h0;
            @(posedge mclk);
            chk("suppressed", {30'h0, r[2], 1'h0}, {30'h0, instr_suppressed_r, skip_pending_r});
        end
        {ext_request_set, conv_done_set} <= 2'h2;
        @(posedge mclk);
        {ext_request_set, conv_done_set} <= 2'h0;
        slot(10'h026, 4'h3, 4'h3);
        slot(10'h038, 4'h0, 4'h0);
        instr_valid <= 1'h0;
        @(posedge mclk);
        chk("refused", 32'h6, {29'h0, ext_request_flag_r, instr_suppressed_r, skip_taken_r});
        bus(1'h0, 8'h0c, 32'h0);
        chk("status", 32'h1, rd);
        bus(1'h1, 8'h08, 32'hffff_fff5);
        bus(1'h0, 8'h08, 32'h0);
        chk("input ctrl", 32'h5, rd);
        bus(1'h0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        bus(1'h0, 8'h08, 32'h0);
        chk("reset", 32'h0, {rd[31:1], ext_request_flag_r});
        conclude();
    end
endmodule
`default_nettype wire
